//--- src/boc_pkg.sv
// Contract
// - Unbuffered compare write takes effect immediately
// - Passed-over new value gives no match
// - Unsynced update may disturb two periods
// - Lower value from compare interrupt handler
// - Compare interrupt raised on counter match
// - Raise value from overflow interrupt handler
// - Overflow interrupt raised when counter wraps
// - Even link bit pairs channels 0-1/2-3/4-5
// - After linking, even compare governs output
// - Last written set takes over at overflow
// - Even control governs pair, odd ignored
// - Odd pin released while pair linked
// - Software writes only the inactive set
// - Toggle-on-overflow toggles pin at modulo
// - Pulse lasts from overflow to compare
// - Edge select low picks pulse polarity
// - Modulo 255 at divide-one: 256 clocks
// - Compare 128 gives 128 of 256 counts
// - Compare sets, clears or toggles pin
// - Shared 16-bit counter, prescaled bus clock
package boc_pkg;
    localparam int NUM_CHAN = 6;
    localparam int NUM_PAIR = 3;
    localparam int ADDR_W = 6;
    localparam int DATA_W = 8;
    localparam int CNT_W = 16;
    localparam int PRE_W = 7;

    // ****************************************
    // Timer register indices (one byte each)
    // ****************************************
    localparam logic [5:0] REG_TCTL = 6'h00;
    localparam logic [5:0] REG_CNT_HI = 6'h01;
    localparam logic [5:0] REG_CNT_LO = 6'h02;
    localparam logic [5:0] REG_MOD_HI = 6'h03;
    localparam logic [5:0] REG_MOD_LO = 6'h04;
    localparam logic [5:0] REG_CH_BASE = 6'h05;
    localparam logic [5:0] REG_CH_STRIDE = 6'h03;
    localparam logic [5:0] REG_CH_CTL = 6'h00;
    localparam logic [5:0] REG_CH_HI = 6'h01;
    localparam logic [5:0] REG_CH_LO = 6'h02;

    // Timer control fields
    localparam int TCTL_OVF_FLAG = 7;
    localparam int TCTL_OVF_IE = 6;
    localparam int TCTL_STOP = 5;
    localparam int TCTL_RST = 4;
    localparam int TCTL_PS_LSB = 0;
    localparam logic [7:0] TCTL_RESET = 8'h20;
    localparam logic [15:0] MOD_RESET = 16'hffff;
    localparam logic [2:0] PS_MAX = 3'h6;

    // Channel control fields
    localparam int CH_FLAG = 7;
    localparam int CH_IE = 6;
    localparam int CH_LINK = 5;
    localparam int CH_MSA = 4;
    localparam int CH_ELSB = 3;
    localparam int CH_ELSA = 2;
    localparam int CH_TOV = 1;
    localparam int CH_MAX = 0;
    localparam logic [7:0] CH_CTL_RESET = 8'h00;

    // Compare pin actions {elsb, elsa}
    localparam logic [1:0] ACT_NONE = 2'h0;
    localparam logic [1:0] ACT_TOGGLE = 2'h1;
    localparam logic [1:0] ACT_CLEAR = 2'h2;
    localparam logic [1:0] ACT_SET = 2'h3;

    // ****************************************
    // Host APB register map
    // ****************************************
    localparam logic [7:0] APB_CMD = 8'h00;
    localparam logic [7:0] APB_STAT = 8'h04;
    localparam int CMD_READ = 16;
    localparam int CMD_ADDR_LSB = 8;
    localparam int STAT_BUSY = 8;
    localparam int STAT_CHIRQ_LSB = 9;
    localparam int STAT_OVFIRQ = 15;

    typedef enum logic [2:0] {
        BOC_IDLE = 3'b001,
        BOC_ISSUE = 3'b010,
        BOC_CAPT = 3'b100
    } boc_host_state_e;
endpackage

//--- src/boc_bus_if.sv
`timescale 1ns/1ps
`default_nettype none
interface boc_bus_if;
    logic wr_en;
    logic rd_en;
    logic [5:0] addr;
    logic [7:0] wdata;
    logic [7:0] rdata;
    logic [5:0] chan_irq;
    logic ovf_irq;

    modport timer (
        input wr_en, rd_en, addr, wdata,
        output rdata, chan_irq, ovf_irq
    );
    modport core (
        output wr_en, rd_en, addr, wdata,
        input rdata, chan_irq, ovf_irq
    );
endinterface
`default_nettype wire

//--- src/boc_timer.sv
// Design decisions made here: the address map and register access over the timer bus.
`timescale 1ns/1ps
`default_nettype none
module boc_timer (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic ce,
    // Register port
    boc_bus_if.timer bus,
    // Channel pins
    output logic [boc_pkg::NUM_CHAN-1:0] chan_pin_o,
    output logic [boc_pkg::NUM_CHAN-1:0] chan_pin_oe
);
    import boc_pkg::*;

    // ****************************************
    // Global control and counter
    // ****************************************
    logic [7:0] tctl_q;
    logic [15:0] cnt_q;
    logic [15:0] mod_q;
    logic [7:0] mod_hi_q;
    logic [6:0] pre_q;
    logic [2:0] ps_eff;
    logic [6:0] pre_mask;
    logic tick;
    logic ovf;
    logic [15:0] cnt_nx;
    logic wr_tctl;

    assign wr_tctl = ce && bus.wr_en && (bus.addr == REG_TCTL);
    assign ps_eff = (tctl_q[TCTL_PS_LSB +: 3] > PS_MAX) ? PS_MAX : tctl_q[TCTL_PS_LSB +: 3];
    assign pre_mask = 7'h7f >> (3'h7 - ps_eff);
    assign tick = ce && !tctl_q[TCTL_STOP] && ((pre_q & pre_mask) == pre_mask);
    assign ovf = tick && (cnt_q == mod_q);
    assign cnt_nx = ovf ? 16'h0000 : cnt_q + 16'h0001;

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            cnt_q <= 16'h0000;
            pre_q <= 7'h00;
        end else if (wr_tctl && bus.wdata[TCTL_RST]) begin
            cnt_q <= 16'h0000;
            pre_q <= 7'h00;
        end else if (ce && !tctl_q[TCTL_STOP]) begin
            pre_q <= pre_q + 7'h01;
            if (tick) begin
                cnt_q <= cnt_nx;
            end
        end
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            tctl_q <= TCTL_RESET;
        end else if (ce) begin
            tctl_q[TCTL_OVF_FLAG] <= ovf || (tctl_q[TCTL_OVF_FLAG]
                && !(wr_tctl && !bus.wdata[TCTL_OVF_FLAG]));
            if (wr_tctl) begin
                tctl_q[TCTL_OVF_IE] <= bus.wdata[TCTL_OVF_IE];
                tctl_q[TCTL_STOP] <= bus.wdata[TCTL_STOP];
                tctl_q[TCTL_PS_LSB +: 3] <= bus.wdata[TCTL_PS_LSB +: 3];
            end
        end
    end

    // Modulo: high byte held until the low byte completes the word
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            mod_q <= MOD_RESET;
            mod_hi_q <= MOD_RESET[15:8];
        end else if (ce && bus.wr_en) begin
            if (bus.addr == REG_MOD_HI) begin
                mod_hi_q <= bus.wdata;
            end else if (bus.addr == REG_MOD_LO) begin
                mod_q <= {mod_hi_q, bus.wdata};
            end
        end
    end

    assign bus.ovf_irq = tctl_q[TCTL_OVF_FLAG] && tctl_q[TCTL_OVF_IE];

    // ****************************************
    // Channels
    // ****************************************
    logic [7:0] ctl_q [NUM_CHAN];
    logic [15:0] cmp_q [NUM_CHAN];
    logic [7:0] cmp_hi_q [NUM_CHAN];
    logic [NUM_CHAN-1:0] inh_q;
    logic [NUM_CHAN-1:0] lo_wr;
    logic [NUM_CHAN-1:0] match;
    logic [NUM_CHAN-1:0] pin_q;
    logic [NUM_CHAN-1:0] linked;
    logic [NUM_PAIR-1:0] act_odd_q;
    logic [NUM_PAIR-1:0] last_odd_q;

    genvar gi;
    generate
        for (gi = 0; gi < NUM_CHAN; gi = gi + 1) begin : g_ch
            localparam logic [5:0] BASE = 6'(REG_CH_BASE + REG_CH_STRIDE * gi);
            localparam int EVEN = gi - (gi % 2);
            logic wr_ctl;
            logic wr_hi;
            logic [15:0] cmp_eff;
            logic [1:0] act;
            logic pin_d;

            // even link bit joins the pair
            assign linked[gi] = ctl_q[EVEN][CH_LINK];
            assign wr_ctl = ce && bus.wr_en && (bus.addr == BASE + REG_CH_CTL)
                && !((gi % 2 == 1) && linked[gi]);
            assign wr_hi = ce && bus.wr_en && (bus.addr == BASE + REG_CH_HI);
            assign lo_wr[gi] = ce && bus.wr_en && (bus.addr == BASE + REG_CH_LO);

            // compare word written straight into the live value
            always_ff @(posedge clk_sys or negedge rst_b) begin
                if (!rst_b) begin
                    cmp_q[gi] <= 16'h0000;
                    cmp_hi_q[gi] <= 8'h00;
                    inh_q[gi] <= 1'b0;
                end else if (wr_hi) begin
                    cmp_hi_q[gi] <= bus.wdata;
                    inh_q[gi] <= 1'b1;
                end else if (lo_wr[gi]) begin
                    cmp_q[gi] <= {cmp_hi_q[gi], bus.wdata};
                    inh_q[gi] <= 1'b0;
                end
            end

            always_ff @(posedge clk_sys or negedge rst_b) begin
                if (!rst_b) begin
                    ctl_q[gi] <= CH_CTL_RESET;
                end else if (ce) begin
                    // flag on match, set beats clear
                    ctl_q[gi][CH_FLAG] <= match[gi] || (ctl_q[gi][CH_FLAG]
                        && !(wr_ctl && !bus.wdata[CH_FLAG]));
                    if (wr_ctl) begin
                        ctl_q[gi][6:0] <= bus.wdata[6:0];
                    end
                end
            end

            // linked even uses whichever set is active
            if (gi % 2 == 0) begin : g_sel
                assign cmp_eff = (linked[gi] && act_odd_q[gi/2]) ? cmp_q[gi+1] : cmp_q[gi];
            end else begin : g_own
                assign cmp_eff = cmp_q[gi];
            end

            // equality on the step only, a passed value never hits
            assign match[gi] = tick && (cnt_nx == cmp_eff) && !inh_q[gi]
                && !(inh_q[EVEN] && linked[gi])
                && !((gi % 2 == 1) && linked[gi]);
            assign act = {ctl_q[gi][CH_ELSB], ctl_q[gi][CH_ELSA]};

            always_comb begin
                pin_d = pin_q[gi];
                if (ovf && ctl_q[gi][CH_TOV]) begin
                    pin_d = ~pin_d;
                end
                // compare action; full duty suppresses it
                if (match[gi] && !ctl_q[gi][CH_MAX]) begin
                    case (act)
                        ACT_TOGGLE: pin_d = ~pin_q[gi];
                        ACT_CLEAR: pin_d = 1'b0;
                        ACT_SET: pin_d = 1'b1;
                        default: pin_d = pin_d;
                    endcase
                end
            end

            always_ff @(posedge clk_sys or negedge rst_b) begin
                if (!rst_b) begin
                    pin_q[gi] <= 1'b0;
                end else if (ce && !((gi % 2 == 1) && linked[gi])) begin
                    pin_q[gi] <= pin_d;
                end
            end

            assign chan_pin_o[gi] = pin_q[gi];
            // odd pin handed back while linked
            assign chan_pin_oe[gi] = (act != ACT_NONE) && !((gi % 2 == 1) && linked[gi]);
            assign bus.chan_irq[gi] = ctl_q[gi][CH_FLAG] && ctl_q[gi][CH_IE];
        end

        // ****************************************
        // Buffered pair selection
        // ****************************************
        for (gi = 0; gi < NUM_PAIR; gi = gi + 1) begin : g_pair
            logic link_set;
            assign link_set = ce && bus.wr_en && bus.wdata[CH_LINK] && !linked[2*gi]
                && (bus.addr == 6'(REG_CH_BASE + REG_CH_STRIDE * 2 * gi));
            always_ff @(posedge clk_sys or negedge rst_b) begin
                if (!rst_b) begin
                    act_odd_q[gi] <= 1'b0;
                    last_odd_q[gi] <= 1'b0;
                end else if (link_set) begin
                    // even set governs right after linking
                    act_odd_q[gi] <= 1'b0;
                    last_odd_q[gi] <= 1'b0;
                end else if (ce) begin
                    if (lo_wr[2*gi+1]) begin
                        last_odd_q[gi] <= 1'b1;
                    end else if (lo_wr[2*gi]) begin
                        last_odd_q[gi] <= 1'b0;
                    end
                    if (ovf) begin
                        act_odd_q[gi] <= lo_wr[2*gi+1] ? 1'b1
                            : (lo_wr[2*gi] ? 1'b0 : last_odd_q[gi]);
                    end
                end
            end
        end
    endgenerate

    // ****************************************
    // Read back
    // ****************************************
    logic [7:0] rd_d;
    logic [5:0] ch_off;
    always_comb begin
        rd_d = 8'h00;
        ch_off = 6'h00;
        case (bus.addr)
            REG_TCTL: rd_d = tctl_q;
            REG_CNT_HI: rd_d = cnt_q[15:8];
            REG_CNT_LO: rd_d = cnt_q[7:0];
            REG_MOD_HI: rd_d = mod_q[15:8];
            REG_MOD_LO: rd_d = mod_q[7:0];
            default: begin
                for (int i = 0; i < NUM_CHAN; i++) begin
                    ch_off = 6'(REG_CH_BASE + REG_CH_STRIDE * i);
                    if (bus.addr == ch_off + REG_CH_CTL) begin
                        rd_d = ctl_q[i];
                    end else if (bus.addr == ch_off + REG_CH_HI) begin
                        rd_d = cmp_q[i][15:8];
                    end else if (bus.addr == ch_off + REG_CH_LO) begin
                        rd_d = cmp_q[i][7:0];
                    end
                end
            end
        endcase
    end

    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            bus.rdata <= 8'h00;
        end else if (ce && bus.rd_en) begin
            bus.rdata <= rd_d;
        end
    end
endmodule
`default_nettype wire

//--- src/boc_core.sv
`timescale 1ns/1ps
`default_nettype none
module boc_core (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    input wire logic ce,
    // APB slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // Timer side
    boc_bus_if.core bus
);
    import boc_pkg::*;

    boc_host_state_e st_q;
    logic [31:0] cmd_q;
    logic [7:0] rdat_q;
    logic acc;
    logic take;

    assign acc = ce && psel && penable;
    assign take = acc && pwrite && (paddr == APB_CMD) && (st_q == BOC_IDLE);
    assign pready = 1'b1;
    assign pslverr = psel && penable && (paddr != APB_CMD) && (paddr != APB_STAT);

    always_comb begin
        case (paddr)
            APB_CMD: prdata = cmd_q;
            APB_STAT: prdata = {16'h0000, bus.ovf_irq, bus.chan_irq,
                st_q != BOC_IDLE, rdat_q};
            default: prdata = 32'h0000_0000;
        endcase
    end

    // ****************************************
    // Command sequencer
    // ****************************************
    // handler policy is left to software issuing commands
    always_ff @(posedge clk_sys or negedge rst_b) begin
        if (!rst_b) begin
            st_q <= BOC_IDLE;
            cmd_q <= 32'h0000_0000;
            rdat_q <= 8'h00;
        end else if (ce) begin
            case (st_q)
                BOC_IDLE: begin
                    if (take) begin
                        cmd_q <= pwdata;
                        st_q <= BOC_ISSUE;
                    end
                end
                BOC_ISSUE: begin
                    st_q <= cmd_q[CMD_READ] ? BOC_CAPT : BOC_IDLE;
                end
                BOC_CAPT: begin
                    rdat_q <= bus.rdata;
                    st_q <= BOC_IDLE;
                end
                default: st_q <= BOC_IDLE;
            endcase
        end
    end

    assign bus.wr_en = (st_q == BOC_ISSUE) && !cmd_q[CMD_READ];
    assign bus.rd_en = (st_q == BOC_ISSUE) && cmd_q[CMD_READ];
    assign bus.addr = cmd_q[CMD_ADDR_LSB +: 6];
    assign bus.wdata = cmd_q[7:0];
endmodule
`default_nettype wire

//--- sim/boc_assertions.sv
`timescale 1ns/1ps
`default_nettype none
module boc_assertions
    import boc_pkg::*;
(
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_b,
    // Timer bus strobes
    input wire logic wr_en,
    input wire logic rd_en,
    input wire logic [5:0] addr,
    input wire logic [7:0] wdata,
    // Timer answers
    input wire logic [7:0] rdata,
    input wire logic [5:0] chan_irq,
    input wire logic ovf_irq
);
    // ****************************************
    // Bus strobe shape
    // ****************************************
    default clocking dc @(posedge clk_sys);
    endclocking
    default disable iff (!rst_b);

    AST_WR_PULSE: assert property (wr_en |=> !wr_en)
        else $error("write strobe longer than one cycle");
    AST_RD_PULSE: assert property ($rose(rd_en) |=> $fell(rd_en))
        else $error("read strobe longer than one cycle");
    AST_NO_WR_RD: assert property (!(wr_en && rd_en))
        else $error("read and write strobes together");
    AST_RDATA_HOLD: assert property ($changed(rdata) |-> $past(rd_en))
        else $error("read byte changed without a read");

    // ****************************************
    // Interrupt requests
    // ****************************************
    // Flags only drop through a register write, never on their own
    AST_OVF_FALL: assert property ($fell(ovf_irq) |-> $past(wr_en) && $past(addr) == REG_TCTL)
        else $error("overflow request dropped without a control write");
    AST_CHIRQ_FALL: assert property (|($past(chan_irq) & ~chan_irq) |-> $past(wr_en))
        else $error("compare request dropped without a write");
    AST_OVF_IE_OFF: assert property (wr_en && addr == REG_TCTL && !wdata[TCTL_OVF_IE] |=> !ovf_irq)
        else $error("overflow request stayed with enable off");
    AST_CH0_IE_OFF: assert property (wr_en && addr == REG_CH_BASE && !wdata[CH_IE] |=> !chan_irq[0])
        else $error("channel 0 request stayed with enable off");

    cover property (wr_en);
    cover property (rd_en ##1 $changed(rdata));
    cover property ($rose(ovf_irq));
    cover property ($rose(chan_irq[0]));
endmodule
`default_nettype wire

//--- sim/test_buffered_output_compare_pwm.sv
`timescale 1ns/1ps
`default_nettype none
module test_buffered_output_compare_pwm;
    import boc_pkg::*;
    // ****************************************
    // Signals and instances
    // ****************************************
    typedef struct {int ch; logic [1:0] act; logic tov; logic [7:0] cmp; int hi; int rise;} boc_row_s;
    logic clk_sys, rst_b, ce, psel, penable, pwrite, pready, pslverr, e;
    logic [7:0] paddr, q;
    logic [31:0] pwdata, prdata, r;
    logic [5:0] pin, oe;
    int n_errors, total_checks, cyc, hi, rise;
    boc_row_s rows[4];

    boc_bus_if boc_bus_if_inst();
    boc_timer boc_timer_inst(.clk_sys(clk_sys), .rst_b(rst_b), .ce(ce), .bus(boc_bus_if_inst),
        .chan_pin_o(pin), .chan_pin_oe(oe));
    boc_core boc_core_inst(.clk_sys(clk_sys), .rst_b(rst_b), .ce(ce), .psel(psel),
        .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
        .pready(pready), .pslverr(pslverr), .bus(boc_bus_if_inst));
    boc_assertions boc_assertions_inst(.clk_sys(clk_sys), .rst_b(rst_b),
        .wr_en(boc_bus_if_inst.wr_en), .rd_en(boc_bus_if_inst.rd_en),
        .addr(boc_bus_if_inst.addr), .wdata(boc_bus_if_inst.wdata),
        .rdata(boc_bus_if_inst.rdata), .chan_irq(boc_bus_if_inst.chan_irq),
        .ovf_irq(boc_bus_if_inst.ovf_irq));

    initial begin
        clk_sys = 1'b0;
        forever #20 clk_sys = ~clk_sys;
    end

    // Whole run is near 12000 cycles; the ceiling leaves a wide margin
    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 40000) begin
            n_errors++;
            final_report();
        end
    end

    // ****************************************
    // Tasks
    // ****************************************
    task final_report;
        $display("checks %0d errors %0d", total_checks, n_errors);
        if (n_errors == 0 && total_checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask

    task chk(input string nm, input logic [31:0] exp, input logic [31:0] got);
        total_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %s expected %0h seen %0h", nm, exp, got);
        end
    endtask

    task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
        output logic [31:0] rd, output logic err);
        @(posedge clk_sys);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clk_sys);
        penable <= 1'b1;
        // A missing answer ends in the bench timeout
        do begin
            @(posedge clk_sys);
        end while (pready !== 1'b1);
        rd = prdata;
        err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    // Busy is polled on both sides so a command is never dropped silently
    task tx(input logic rd, input logic [5:0] idx, input logic [7:0] b, output logic [7:0] qo);
        logic [31:0] s;
        logic er;
        do begin
            apb(1'b0, APB_STAT, 32'h0, s, er);
        end while (s[STAT_BUSY] !== 1'b0);
        apb(1'b1, APB_CMD, {15'h0, rd, 2'h0, idx, b}, s, er);
        do begin
            apb(1'b0, APB_STAT, 32'h0, s, er);
        end while (s[STAT_BUSY] !== 1'b0);
        qo = s[7:0];
    endtask

    task tw(input logic [5:0] idx, input logic [7:0] b);
        logic [7:0] qo;
        tx(1'b0, idx, b, qo);
    endtask

    function automatic logic [5:0] ci(input int n, input logic [5:0] off);
        return REG_CH_BASE + 6'(n * REG_CH_STRIDE) + off;
    endfunction

    task w16(input int n, input logic [15:0] v);
        tw(ci(n, REG_CH_HI), v[15:8]);
        tw(ci(n, REG_CH_LO), v[7:0]);
    endtask

    task tstart;
        tw(REG_TCTL, 8'h30);
        tw(REG_MOD_HI, 8'h00);
        tw(REG_MOD_LO, 8'hff);
    endtask

    // Three settling periods absorb the unsynced-update window
    task meas(input int ch, output int h, output int rs);
        logic p;
        h = 0;
        rs = 0;
        repeat (768) @(posedge clk_sys);
        @(negedge clk_sys);
        p = pin[ch];
        repeat (512) begin
            @(negedge clk_sys);
            if (pin[ch] === 1'b1) h++;
            if (pin[ch] === 1'b1 && p === 1'b0) rs++;
            p = pin[ch];
        end
    endtask

    // A pin that never moves ends in the bench timeout
    task waitpin(input int ch, input logic v);
        while (pin[ch] !== v) begin
            @(negedge clk_sys);
        end
    endtask

    // ****************************************
    // Main sequence
    // ****************************************
    initial begin
        ce = 1'b1;
        rst_b = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 8'h00;
        pwdata = 32'h0;
        rows[0] = '{0, ACT_CLEAR, 1'b1, 8'h80, 256, 2};
        rows[1] = '{2, ACT_SET, 1'b1, 8'h40, 384, 2};
        rows[2] = '{4, ACT_CLEAR, 1'b1, 8'h01, 2, 2};
        rows[3] = '{1, ACT_TOGGLE, 1'b0, 8'h32, 256, 1};
        repeat (4) @(posedge clk_sys);
        chk("pins in reset", 32'h0, {26'h0, pin});
        chk("oe in reset", 32'h0, {26'h0, oe});
        rst_b <= 1'b1;
        apb(1'b0, APB_STAT, 32'h0, r, e);
        chk("stat", 32'h0, r);
        apb(1'b0, 8'h08, 32'h0, r, e);
        chk("unmapped err", 32'h1, {31'h0, e});
        chk("unmapped data", 32'h0, r);
        tx(1'b1, REG_TCTL, 8'h00, q);
        chk("tctl reset", {24'h0, TCTL_RESET}, {24'h0, q});
        tx(1'b1, REG_MOD_HI, 8'h00, q);
        chk("mod hi reset", {24'h0, MOD_RESET[15:8]}, {24'h0, q});
        tx(1'b1, ci(0, REG_CH_CTL), 8'h00, q);
        chk("ch ctl reset", {24'h0, CH_CTL_RESET}, {24'h0, q});
        foreach (rows[i]) begin
            tstart();
            w16(rows[i].ch, {8'h00, rows[i].cmp});
            tw(ci(rows[i].ch, REG_CH_CTL), {4'h4, rows[i].act, rows[i].tov, 1'b0});
            tw(REG_TCTL, 8'h40);
            meas(rows[i].ch, hi, rise);
            chk("high count", rows[i].hi, hi);
            chk("rise count", rows[i].rise, rise);
            chk("pin enable", 32'h1, {31'h0, oe[rows[i].ch]});
            apb(1'b0, APB_STAT, 32'h0, r, e);
            chk("ovf request", 32'h1, {31'h0, r[STAT_OVFIRQ]});
            chk("cmp request", 32'h1, {31'h0, r[STAT_CHIRQ_LSB + rows[i].ch]});
        end
        // Buffered pair 2-3, odd set written before linking
        tstart();
        w16(2, 16'h0028);
        w16(3, 16'h00c8);
        // Odd pin driven before linking; earlier match flag cleared
        tw(ci(3, REG_CH_CTL), 8'h08);
        chk("odd pin driven", 32'h1, {31'h0, oe[3]});
        tw(ci(2, REG_CH_CTL), 8'h2a);
        tw(REG_TCTL, 8'h40);
        meas(2, hi, rise);
        chk("linked even width", 80, hi);
        chk("odd pin released", 32'h0, {31'h0, oe[3]});
        tw(ci(3, REG_CH_CTL), 8'h4e);
        tx(1'b1, ci(3, REG_CH_CTL), 8'h00, q);
        chk("odd ctl ignored", 32'h8, {24'h0, q});
        chk("odd pin still released", 32'h0, {31'h0, oe[3]});
        w16(3, 16'h00c8);
        meas(2, hi, rise);
        chk("odd set width", 400, hi);
        w16(2, 16'h0064);
        meas(2, hi, rise);
        chk("even set width", 200, hi);
        // Unbuffered value written after the counter passed it
        w16(0, 16'h00c8);
        repeat (768) @(posedge clk_sys);
        waitpin(0, 1'b0);
        waitpin(0, 1'b1);
        repeat (100) @(posedge clk_sys);
        tw(ci(0, REG_CH_CTL), 8'h0a);
        w16(0, 16'h0064);
        waitpin(0, 1'b0);
        tx(1'b1, ci(0, REG_CH_CTL), 8'h00, q);
        chk("no match flag", 32'h0, {31'h0, q[CH_FLAG]});
        meas(0, hi, rise);
        chk("direct width", 200, hi);
        // Clock enable low must hold every pin for longer than a period
        @(posedge clk_sys);
        ce <= 1'b0;
        @(posedge clk_sys);
        r = {26'h0, pin};
        repeat (300) @(negedge clk_sys);
        chk("frozen pins", r, {26'h0, pin});
        @(posedge clk_sys);
        ce <= 1'b1;
        final_report();
    end
endmodule
`default_nettype wire
